/* core/jifa_top.sv */
// Boundary scan and indirect flash register access over the test port
`timescale 1ns/1ps
`default_nettype none
`include "jifa_consts.svh"
module jifa_top #(
    // Identity value is arbitrary
    parameter logic [`JIFA_ID_W-1:0] ID_CODE = `JIFA_ID_DEFAULT
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Test port
    input wire logic jtag_tck_i,
    input wire logic jtag_tms_i,
    input wire logic jtag_tdi_i,
    output logic jtag_tdo_o,
    output logic jtag_tdo_oe_o,
    // Device pins
    input wire logic [`JIFA_NPINS-1:0] pin_in_i,
    output logic [`JIFA_NPINS-1:0] pin_out_o,
    output logic [`JIFA_NPINS-1:0] pin_oe_o,
    output logic pullup_en_o,
    // On-chip logic side of the pins
    input wire logic [`JIFA_NPINS-1:0] core_out_i,
    input wire logic [`JIFA_NPINS-1:0] core_oe_i,
    input wire logic core_pullup_i,
    output logic [`JIFA_NPINS-1:0] core_in_o,
    // Flash controller
    output logic flash_req_o,
    output logic flash_we_o,
    output logic [`JIFA_FADR_W-1:0] flash_addr_o,
    output logic [7:0] flash_wdata_o,
    output logic flash_scratch_o,
    output logic [`JIFA_FCTL_W-1:0] flash_ctrl_o,
    output logic [`JIFA_FSCL_W-1:0] flash_scale_o,
    input wire logic flash_done_i,
    input wire logic flash_fail_i,
    input wire logic [7:0] flash_rdata_i
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);

    function automatic logic is_ind(input logic [`JIFA_IR_W-1:0] ir);
        return (ir == `JIFA_IR_FL_CTRL) || (ir == `JIFA_IR_FL_DATA) ||
               (ir == `JIFA_IR_FL_ADDR) || (ir == `JIFA_IR_FL_SCALE);
    endfunction

    // Samplers for test port and pins
    logic [2:0] tck_s_q;
    logic [1:0] tms_s_q;
    logic [1:0] tdi_s_q;
    logic [`JIFA_NPINS-1:0] pin_s1_q;
    logic [`JIFA_NPINS-1:0] pin_s2_q;
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tck_s_q <= 3'h0;
            tms_s_q <= 2'h3;
            tdi_s_q <= 2'h0;
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            tck_s_q <= {tck_s_q[1:0], jtag_tck_i};
            tms_s_q <= {tms_s_q[0], jtag_tms_i};
            tdi_s_q <= {tdi_s_q[0], jtag_tdi_i};
            pin_s1_q <= pin_in_i;
            pin_s2_q <= pin_s1_q;
        end
    end

    logic tck_rise;
    logic tck_fall;
    logic tdi;
    assign tck_rise = tck_s_q[1] & ~tck_s_q[2];
    assign tck_fall = ~tck_s_q[1] & tck_s_q[2];
    assign tdi = tdi_s_q[1];

    jifa_pkg::jifa_tap_state_t tap_st;
    jifa_tap_fsm u_tap (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .step_i(tck_rise),
        .tms_i(tms_s_q[1]),
        .state_o(tap_st)
    );

    // State strobes at test clock rises
    logic cap_ir;
    logic sh_ir;
    logic upd_ir;
    logic cap_dr;
    logic sh_dr;
    logic upd_dr;
    assign cap_ir = tck_rise && (tap_st == jifa_pkg::TS_CAP_IR);
    assign sh_ir = tck_rise && (tap_st == jifa_pkg::TS_SH_IR);
    assign upd_ir = tck_rise && (tap_st == jifa_pkg::TS_UPD_IR);
    assign cap_dr = tck_rise && (tap_st == jifa_pkg::TS_CAP_DR);
    assign sh_dr = tck_rise && (tap_st == jifa_pkg::TS_SH_DR);
    assign upd_dr = tck_rise && (tap_st == jifa_pkg::TS_UPD_DR);

    // Instruction register
    logic [`JIFA_IR_W-1:0] ir_sr_q;
    logic [`JIFA_IR_W-1:0] ir_q;
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ir_sr_q <= '0;
            ir_q <= `JIFA_IR_IDCODE;
        end else if (tap_st == jifa_pkg::TS_RESET) begin
            ir_q <= `JIFA_IR_IDCODE;
        end else if (cap_ir) begin
            ir_sr_q <= `JIFA_IR_CAPTURE;
        end else if (sh_ir) begin
            ir_sr_q <= {tdi, ir_sr_q[`JIFA_IR_W-1:1]};
        end else if (upd_ir) begin
            ir_q <= ir_sr_q;
        end
    end

    logic ir_extest;
    logic ir_sample;
    logic ir_idcode;
    logic ir_ind;
    logic ir_byp;
    assign ir_extest = (ir_q == `JIFA_IR_EXTEST);
    assign ir_sample = (ir_q == `JIFA_IR_SAMPLE);
    assign ir_idcode = (ir_q == `JIFA_IR_IDCODE);
    assign ir_ind = is_ind(ir_q);
    assign ir_byp = !(ir_extest || ir_sample || ir_idcode || ir_ind);

    // Bypass and identity registers
    logic byp_q;
    logic [`JIFA_ID_W-1:0] id_sr_q;
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            byp_q <= 1'b0;
        end else if (cap_dr && ir_byp) begin
            byp_q <= 1'b0;
        end else if (sh_dr && ir_byp) begin
            byp_q <= tdi;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            id_sr_q <= '0;
        end else if (cap_dr && ir_idcode) begin
            id_sr_q <= ID_CODE;
        end else if (sh_dr && ir_idcode) begin
            id_sr_q <= {tdi, id_sr_q[`JIFA_ID_W-1:1]};
        end
    end

    // Boundary cells: pull-up, then output enable and data per pin
    logic [`JIFA_BSR_W-1:0] bsr_cap;
    logic [`JIFA_BSR_W-1:0] bsr_sr_q;
    logic [`JIFA_BSR_W-1:0] bsr_upd_q;
    logic [`JIFA_NPINS-1:0] upd_oe;
    logic [`JIFA_NPINS-1:0] upd_out;
    assign bsr_cap[`JIFA_BSR_PULLUP] = core_pullup_i;
    for (genvar n = 0; n < `JIFA_NPINS; n++) begin : g_cell
        assign bsr_cap[1 + 2 * n] = core_oe_i[n];
        assign bsr_cap[2 + 2 * n] = pin_s2_q[n];
        assign upd_oe[n] = bsr_upd_q[1 + 2 * n];
        assign upd_out[n] = bsr_upd_q[2 + 2 * n];
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bsr_sr_q <= '0;
        end else if (cap_dr && (ir_extest || ir_sample)) begin
            bsr_sr_q <= bsr_cap;
        end else if (sh_dr && (ir_extest || ir_sample)) begin
            bsr_sr_q <= {tdi, bsr_sr_q[`JIFA_BSR_W-1:1]};
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bsr_upd_q <= '0;
        end else if (upd_dr && ir_extest) begin
            bsr_upd_q <= bsr_sr_q;
        end
    end

    // Pin and core drive
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_out_o <= '0;
            pin_oe_o <= '0;
            pullup_en_o <= 1'b0;
            core_in_o <= '0;
        end else if (ir_extest) begin
            pin_out_o <= upd_out;
            pin_oe_o <= upd_oe;
            pullup_en_o <= bsr_upd_q[`JIFA_BSR_PULLUP];
            core_in_o <= {`JIFA_NPINS{1'b1}};
        end else begin
            pin_out_o <= core_out_i;
            pin_oe_o <= core_oe_i;
            pullup_en_o <= core_pullup_i;
            core_in_o <= pin_s2_q;
        end
    end

    // Indirect command register
    logic [`JIFA_IND_W-1:0] ind_sr_q;
    logic [`JIFA_PAY_W-1:0] fetched_payload;
    logic ind_busy_q;
    logic [1:0] indirect_operation_code;
    logic [`JIFA_PAY_W-1:0] store_payload;
    logic ind_upd;
    logic ind_start;
    assign indirect_operation_code = ind_sr_q[`JIFA_OP_HI:`JIFA_OP_LO];
    assign store_payload = ind_sr_q[`JIFA_PAY_W-1:0];
    assign ind_upd = upd_dr && ir_ind;
    // Poll never starts; busy drops commands
    assign ind_start = ind_upd && indirect_operation_code[1] && !ind_busy_q;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ind_sr_q <= '0;
        end else if (cap_dr && ir_ind) begin
            ind_sr_q <= {1'b0, fetched_payload, ind_busy_q};
        end else if (sh_dr && ir_ind) begin
            ind_sr_q <= {tdi, ind_sr_q[`JIFA_IND_W-1:1]};
        end
    end

    // Flash-side registers
    logic [`JIFA_FCTL_W-1:0] fctl_q;
    logic [`JIFA_FADR_W-1:0] fadr_q;
    logic [`JIFA_FSCL_W-1:0] fscl_q;
    logic [7:0] fbyte_q;
    logic ffail_q;
    logic fbusy_q;
    logic fl_we_q;
    logic [`JIFA_FDAT_W-1:0] flash_byte_port;
    logic fl_go;
    assign flash_byte_port = {fbyte_q, ffail_q, fbusy_q};
    assign fl_go = ind_start && (ir_q == `JIFA_IR_FL_DATA) && !fbusy_q;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fctl_q <= `JIFA_FCTL_RST;
            fadr_q <= `JIFA_FADR_RST;
            fscl_q <= `JIFA_FSCL_RST;
        end else if (ind_start && indirect_operation_code[0]) begin
            if (ir_q == `JIFA_IR_FL_CTRL) begin
                fctl_q <= store_payload[17:10];
            end
            if (ir_q == `JIFA_IR_FL_ADDR) begin
                fadr_q <= store_payload[17:2];
            end
            if (ir_q == `JIFA_IR_FL_SCALE) begin
                fscl_q <= store_payload[17:10];
            end
        end
    end

    // Flash operation sequencing
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fbyte_q <= 8'(`JIFA_FDAT_RST >> 2);
            ffail_q <= 1'b0;
            fbusy_q <= 1'b0;
            fl_we_q <= 1'b0;
            flash_req_o <= 1'b0;
        end else begin
            flash_req_o <= fl_go;
            if (fl_go) begin
                fbusy_q <= 1'b1;
                fl_we_q <= indirect_operation_code[0];
                if (indirect_operation_code[0]) begin
                    fbyte_q <= store_payload[17:10];
                end
            end else if (fbusy_q && flash_done_i) begin
                fbusy_q <= 1'b0;
                ffail_q <= flash_fail_i;
                if (!fl_we_q) begin
                    fbyte_q <= flash_rdata_i;
                end
            end
        end
    end

    assign flash_we_o = fl_we_q;
    assign flash_addr_o = fadr_q;
    assign flash_wdata_o = fbyte_q;
    assign flash_scratch_o = fctl_q[`JIFA_FCTL_SCRATCH];
    assign flash_ctrl_o = fctl_q;
    assign flash_scale_o = fscl_q;

    // Indirect operation tracking
    logic ind_rd_q;
    logic [`JIFA_IR_W-1:0] ind_sel_q;
    logic [`JIFA_PAY_W-1:0] fetched_q;
    logic [`JIFA_PAY_W-1:0] rd_val;
    always_comb begin
        rd_val = '0;
        case (ind_sel_q)
            `JIFA_IR_FL_CTRL: rd_val[`JIFA_FCTL_W-1:0] = fctl_q;
            `JIFA_IR_FL_ADDR: rd_val[`JIFA_FADR_W-1:0] = fadr_q;
            `JIFA_IR_FL_SCALE: rd_val[`JIFA_FSCL_W-1:0] = fscl_q;
            `JIFA_IR_FL_DATA: rd_val[`JIFA_FDAT_W-1:0] = flash_byte_port;
            default: rd_val = '0;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ind_busy_q <= 1'b0;
            ind_rd_q <= 1'b0;
            ind_sel_q <= '0;
            fetched_q <= '0;
        end else if (ind_start) begin
            ind_busy_q <= 1'b1;
            ind_rd_q <= !indirect_operation_code[0];
            ind_sel_q <= ir_q;
        end else if (ind_busy_q && !fbusy_q) begin
            ind_busy_q <= 1'b0;
            if (ind_rd_q) begin
                fetched_q <= rd_val;
            end
        end
    end
    assign fetched_payload = fetched_q;

    // Test data output, changed at falling edges
    logic dr_lsb;
    always_comb begin
        if (ir_ind) begin
            dr_lsb = ind_sr_q[0];
        end else if (ir_idcode) begin
            dr_lsb = id_sr_q[0];
        end else if (ir_extest || ir_sample) begin
            dr_lsb = bsr_sr_q[0];
        end else begin
            dr_lsb = byp_q;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            jtag_tdo_o <= 1'b0;
            jtag_tdo_oe_o <= 1'b0;
        end else if (tck_fall) begin
            jtag_tdo_oe_o <= (tap_st == jifa_pkg::TS_SH_DR) || (tap_st == jifa_pkg::TS_SH_IR);
            jtag_tdo_o <= (tap_st == jifa_pkg::TS_SH_IR) ? ir_sr_q[0] : dr_lsb;
        end
    end

    // Checks
    AST_EXT_CORE_ONES: assert property (ir_extest && $past(ir_extest) |-> &core_in_o)
        else $error("core inputs not high under external test");
    AST_EXT_PINS: assert property ($past(ir_extest) |-> pin_out_o == $past(upd_out)
        && pin_oe_o == $past(upd_oe))
        else $error("pins not driven from update cells");
    AST_NOEXT_PINS: assert property (!$past(ir_extest) |-> pin_out_o == $past(core_out_i))
        else $error("pins not driven by core outside external test");
    AST_SAMPLE_NO_UPDATE: assert property (upd_dr && ir_sample |=> $stable(bsr_upd_q))
        else $error("sample changed update cells");
    AST_SAMPLE_CAPTURE: assert property (cap_dr && ir_sample |=> bsr_sr_q == $past(bsr_cap))
        else $error("sample capture wrong");
    AST_BYPASS_ZERO: assert property (cap_dr && ir_byp |=> !byp_q)
        else $error("bypass capture not zero");
    AST_ID_LOAD: assert property (cap_dr && ir_idcode |=> id_sr_q == ID_CODE)
        else $error("identity not captured");
    AST_POLL_IDLE: assert property (ind_upd && !ind_sr_q[`JIFA_OP_HI] && !ind_busy_q
        |=> !ind_busy_q ##1 !flash_req_o)
        else $error("poll started an operation");
    AST_RESP_FORMAT: assert property (cap_dr && ir_ind |=> !ind_sr_q[`JIFA_OP_HI]
        && ind_sr_q[0] == $past(ind_busy_q) && ind_sr_q[18:1] == $past(fetched_q))
        else $error("response format wrong");
    AST_BUSY_SET: assert property (ind_start |=> ind_busy_q)
        else $error("busy not set at start");
    AST_BUSY_IGNORED: assert property (ind_upd && ind_busy_q
        |=> $stable(fctl_q) && $stable(fadr_q) && !flash_req_o)
        else $error("command taken while busy");
    AST_FLASH_GATE: assert property (fbusy_q && !flash_done_i |=> !flash_req_o)
        else $error("flash started while busy");
    AST_FAIL_TRACK: assert property (fbusy_q && flash_done_i
        |=> flash_byte_port[`JIFA_FDAT_FAIL] == $past(flash_fail_i))
        else $error("fail flag not recorded");
    AST_SCRATCH: assert property (ind_start && ind_sr_q[`JIFA_OP_LO] && ir_q == `JIFA_IR_FL_CTRL
        |=> flash_scratch_o == $past(ind_sr_q[17]))
        else $error("scratchpad select not written");
endmodule
`default_nettype wire

/* core/jifa_consts.svh */
// Constants for the test-port and indirect flash access block
`ifndef JIFA_CONSTS_SVH
`define JIFA_CONSTS_SVH
`define JIFA_IR_W 4
`define JIFA_IR_EXTEST 4'h0
`define JIFA_IR_CAPTURE 4'h1
`define JIFA_IR_SAMPLE 4'h2
`define JIFA_IR_IDCODE 4'h4
`define JIFA_IR_FL_CTRL 4'h8
`define JIFA_IR_FL_DATA 4'h9
`define JIFA_IR_FL_ADDR 4'hA
`define JIFA_IR_FL_SCALE 4'hB
`define JIFA_IR_BYPASS 4'hF
`define JIFA_IND_W 20
`define JIFA_OP_HI 19
`define JIFA_OP_LO 18
`define JIFA_PAY_W 18
`define JIFA_ID_W 32
`define JIFA_ID_DEFAULT 32'h0A5C_3E01
`define JIFA_NPINS 8
`define JIFA_BSR_W 17
`define JIFA_BSR_PULLUP 0
`define JIFA_FDAT_W 10
`define JIFA_FDAT_FAIL 1
`define JIFA_FDAT_BUSY 0
`define JIFA_FDAT_RST 10'h000
`define JIFA_FCTL_W 8
`define JIFA_FCTL_SCRATCH 7
`define JIFA_FCTL_RST 8'h00
`define JIFA_FADR_W 16
`define JIFA_FADR_RST 16'h0000
`define JIFA_FSCL_W 8
`define JIFA_FSCL_RST 8'h00
`endif

/* core/jifa_pkg.sv */
// Types for the test-port and indirect flash access block
package jifa_pkg;
    typedef enum logic [15:0] {
        TS_RESET = 16'h0001,
        TS_IDLE = 16'h0002,
        TS_SEL_DR = 16'h0004,
        TS_CAP_DR = 16'h0008,
        TS_SH_DR = 16'h0010,
        TS_EX1_DR = 16'h0020,
        TS_PAU_DR = 16'h0040,
        TS_EX2_DR = 16'h0080,
        TS_UPD_DR = 16'h0100,
        TS_SEL_IR = 16'h0200,
        TS_CAP_IR = 16'h0400,
        TS_SH_IR = 16'h0800,
        TS_EX1_IR = 16'h1000,
        TS_PAU_IR = 16'h2000,
        TS_EX2_IR = 16'h4000,
        TS_UPD_IR = 16'h8000
    } jifa_tap_state_t;
endpackage

/* core/jifa_tap_fsm.sv */
// Test-access-port state machine stepped on sampled test clock rises
`timescale 1ns/1ps
`default_nettype none
module jifa_tap_fsm (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Step strobe and mode select
    input wire logic step_i,
    input wire logic tms_i,
    // Current state
    output jifa_pkg::jifa_tap_state_t state_o
);
    jifa_pkg::jifa_tap_state_t st_q;
    jifa_pkg::jifa_tap_state_t st_d;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            jifa_pkg::TS_RESET: st_d = tms_i ? jifa_pkg::TS_RESET : jifa_pkg::TS_IDLE;
            jifa_pkg::TS_IDLE: st_d = tms_i ? jifa_pkg::TS_SEL_DR : jifa_pkg::TS_IDLE;
            jifa_pkg::TS_SEL_DR: st_d = tms_i ? jifa_pkg::TS_SEL_IR : jifa_pkg::TS_CAP_DR;
            jifa_pkg::TS_CAP_DR: st_d = tms_i ? jifa_pkg::TS_EX1_DR : jifa_pkg::TS_SH_DR;
            jifa_pkg::TS_SH_DR: st_d = tms_i ? jifa_pkg::TS_EX1_DR : jifa_pkg::TS_SH_DR;
            jifa_pkg::TS_EX1_DR: st_d = tms_i ? jifa_pkg::TS_UPD_DR : jifa_pkg::TS_PAU_DR;
            jifa_pkg::TS_PAU_DR: st_d = tms_i ? jifa_pkg::TS_EX2_DR : jifa_pkg::TS_PAU_DR;
            jifa_pkg::TS_EX2_DR: st_d = tms_i ? jifa_pkg::TS_UPD_DR : jifa_pkg::TS_SH_DR;
            jifa_pkg::TS_UPD_DR: st_d = tms_i ? jifa_pkg::TS_SEL_DR : jifa_pkg::TS_IDLE;
            jifa_pkg::TS_SEL_IR: st_d = tms_i ? jifa_pkg::TS_RESET : jifa_pkg::TS_CAP_IR;
            jifa_pkg::TS_CAP_IR: st_d = tms_i ? jifa_pkg::TS_EX1_IR : jifa_pkg::TS_SH_IR;
            jifa_pkg::TS_SH_IR: st_d = tms_i ? jifa_pkg::TS_EX1_IR : jifa_pkg::TS_SH_IR;
            jifa_pkg::TS_EX1_IR: st_d = tms_i ? jifa_pkg::TS_UPD_IR : jifa_pkg::TS_PAU_IR;
            jifa_pkg::TS_PAU_IR: st_d = tms_i ? jifa_pkg::TS_EX2_IR : jifa_pkg::TS_PAU_IR;
            jifa_pkg::TS_EX2_IR: st_d = tms_i ? jifa_pkg::TS_UPD_IR : jifa_pkg::TS_SH_IR;
            jifa_pkg::TS_UPD_IR: st_d = tms_i ? jifa_pkg::TS_SEL_DR : jifa_pkg::TS_IDLE;
            default: st_d = jifa_pkg::TS_RESET;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= jifa_pkg::TS_RESET;
        end else if (step_i) begin
            st_q <= st_d;
        end
    end

    assign state_o = st_q;
endmodule
`default_nettype wire

/* verif/jifa_flash_model.sv */
// Behavioural flash controller answering the block's flash requests
`timescale 1ns/1ps
`default_nettype none
module jifa_flash_model (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Requests from the block
    input wire logic flash_req_i,
    input wire logic flash_we_i,
    input wire logic [15:0] flash_addr_i,
    input wire logic [7:0] flash_wdata_i,
    // Bench controls
    input wire logic [9:0] lat_i,
    input wire logic fail_i,
    // Answers
    output logic flash_done_o,
    output logic flash_fail_o,
    output logic [7:0] flash_rdata_o,
    output int req_count_o
);
    logic [7:0] mem [int];
    logic we;
    logic [15:0] adr;
    logic [7:0] wd;
    initial begin
        flash_done_o = 1'b0;
        flash_fail_o = 1'b0;
        flash_rdata_o = 8'h5A;
        req_count_o = 0;
        forever begin
            @(posedge clk_sys_i);
            if (flash_req_i === 1'b1 && sys_rst_i === 1'b0) begin
                req_count_o++;
                we = flash_we_i;
                adr = flash_addr_i;
                wd = flash_wdata_i;
                repeat (lat_i) @(posedge clk_sys_i);
                flash_done_o <= 1'b1;
                flash_fail_o <= fail_i;
                flash_rdata_o <= mem.exists(adr) ? mem[adr] : 8'hFF;
                if (we && !fail_i) mem[adr] = wd;
                @(posedge clk_sys_i);
                // Answer lines do not hold their value after done
                flash_done_o <= 1'b0;
                flash_fail_o <= ~flash_fail_o;
                flash_rdata_o <= ~flash_rdata_o;
            end
        end
    end
endmodule
`default_nettype wire

/* verif/test_jifa_top.sv */
// Self-checking bench for the test-port flash access block
`timescale 1ns/1ps
`default_nettype none
module test_jifa_top;
    // Identity value is arbitrary
    localparam logic [31:0] TB_ID = 32'h1357_9BDF;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic jtag_tck_i = 1'b0;
    logic jtag_tms_i = 1'b1;
    logic jtag_tdi_i = 1'b0;
    logic jtag_tdo_o, jtag_tdo_oe_o, pullup_en_o, core_pullup_i = 1'b0;
    logic [7:0] pin_in_i = 8'h00, core_out_i = 8'h00, core_oe_i = 8'h00;
    logic [7:0] pin_out_o, pin_oe_o, core_in_o, flash_wdata_o, flash_rdata_i;
    logic [7:0] flash_ctrl_o, flash_scale_o, byt;
    logic [15:0] flash_addr_o, addr;
    logic flash_req_o, flash_we_o, flash_scratch_o, flash_done_i, flash_fail_i, b;
    logic [9:0] lat = 10'h001;
    logic fail_mode = 1'b0;
    logic [31:0] r, v;
    logic [3:0] byp [2] = '{4'hF, 4'h5};
    logic [7:0] exp_mem [int];
    int req_count, n_fail = 0, check_count = 0;
    integer seed = 32'h092B031F;

    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    jifa_top #(.ID_CODE(TB_ID)) DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .jtag_tck_i(jtag_tck_i), .jtag_tms_i(jtag_tms_i), .jtag_tdi_i(jtag_tdi_i),
        .jtag_tdo_o(jtag_tdo_o), .jtag_tdo_oe_o(jtag_tdo_oe_o), .pin_in_i(pin_in_i),
        .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pullup_en_o(pullup_en_o),
        .core_out_i(core_out_i), .core_oe_i(core_oe_i), .core_pullup_i(core_pullup_i),
        .core_in_o(core_in_o), .flash_req_o(flash_req_o), .flash_we_o(flash_we_o),
        .flash_addr_o(flash_addr_o), .flash_wdata_o(flash_wdata_o),
        .flash_scratch_o(flash_scratch_o), .flash_ctrl_o(flash_ctrl_o),
        .flash_scale_o(flash_scale_o), .flash_done_i(flash_done_i),
        .flash_fail_i(flash_fail_i), .flash_rdata_i(flash_rdata_i));

    jifa_flash_model flash (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .flash_req_i(flash_req_o), .flash_we_i(flash_we_o), .flash_addr_i(flash_addr_o),
        .flash_wdata_i(flash_wdata_o), .lat_i(lat), .fail_i(fail_mode),
        .flash_done_o(flash_done_i), .flash_fail_o(flash_fail_i),
        .flash_rdata_o(flash_rdata_i), .req_count_o(req_count));

    task automatic tally_and_finish();
        if (n_fail == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic [31:0] bvec(input logic pu, input logic [7:0] oe, input logic [7:0] d);
        bvec = 32'(pu);
        for (int n = 0; n < 8; n++) begin
            bvec[1 + 2 * n] = oe[n];
            bvec[2 + 2 * n] = d[n];
        end
    endfunction

    // One test clock period: low 4 clocks, high 4, data out taken late in high
    task automatic tck_cyc(input logic ms, input logic di, output logic dout);
        @(negedge clk_sys_i);
        jtag_tck_i = 1'b0;
        jtag_tms_i = ms;
        jtag_tdi_i = di;
        repeat (4) @(negedge clk_sys_i);
        jtag_tck_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        dout = jtag_tdo_o;
    endtask

    // Idle to shift, n bits least significant first, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
        output logic [31:0] dout);
        logic t;
        dout = 32'h0;
        tck_cyc(1'b1, 1'b0, t);
        if (ir) tck_cyc(1'b1, 1'b0, t);
        tck_cyc(1'b0, 1'b0, t);
        tck_cyc(1'b0, 1'b0, t);
        for (int i = 0; i < n; i++) begin
            tck_cyc(i == n - 1, din[i], t);
            dout[i] = t;
            if (i == 0) chk("tdo enable", 32'h1, 32'(jtag_tdo_oe_o));
        end
        tck_cyc(1'b1, 1'b0, t);
        tck_cyc(1'b0, 1'b0, t);
    endtask

    task automatic set_ir(input logic [3:0] code);
        logic [31:0] c;
        scan(1'b1, 4, 32'(code), c);
        chk("instruction capture", 32'h1, c);
    endtask

    // Polls until busy is seen low, giving up after 20 scans
    task automatic wait_idle(output logic [31:0] res);
        for (int k = 0; k < 20; k++) begin
            scan(1'b0, 20, 32'h0, res);
            if (res[0] === 1'b0) break;
        end
    endtask

    task automatic wr_ind(input logic [3:0] code, input int w, input logic [31:0] val);
        logic [31:0] c;
        set_ir(code);
        scan(1'b0, w + 2, (32'h3 << w) | val, c);
    endtask

    task automatic rd_ind(input logic [3:0] code, output logic [31:0] res);
        set_ir(code);
        scan(1'b0, 2, 32'h2, res);
        wait_idle(res);
    endtask

    initial begin
        repeat (8) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        tck_cyc(1'b0, 1'b0, b);
        scan(1'b0, 32, 32'h0, r);
        chk("identity", TB_ID, r);
        chk("tdo idle", 32'h0, 32'(jtag_tdo_oe_o));
        for (int i = 0; i < 2; i++) begin
            set_ir(byp[i]);
            scan(1'b0, 4, 32'hB, r);
            chk("bypass", 32'h6, r);
        end
        for (int i = 0; i < 2; i++) begin
            @(negedge clk_sys_i);
            {pin_in_i, core_out_i, core_oe_i} = 24'($random(seed));
            core_pullup_i = 1'($random(seed));
            v = 32'($random(seed)) & 32'h1FFFF;
            set_ir(i ? 4'h2 : 4'h0);
            scan(1'b0, 17, v, r);
            chk("boundary capture", bvec(core_pullup_i, core_oe_i, pin_in_i), r);
            repeat (2) @(negedge clk_sys_i);
            if (i == 0) begin
                chk("pins", v, bvec(pullup_en_o, pin_oe_o, pin_out_o));
                chk("core inputs", 32'hFF, 32'(core_in_o));
            end else begin
                chk("pins", bvec(core_pullup_i, core_oe_i, core_out_i),
                    bvec(pullup_en_o, pin_oe_o, pin_out_o));
                chk("core inputs", 32'(pin_in_i), 32'(core_in_o));
            end
        end
        for (int f = 0; f < 2; f++) begin
            addr = 16'($random(seed));
            byt = 8'($random(seed));
            lat = 10'(($random(seed) & 7) + 1);
            fail_mode = 1'(f);
            wr_ind(4'hA, 16, 32'(addr));
            chk("address", 32'(addr), 32'(flash_addr_o));
            wr_ind(4'h9, 10, 32'({byt, 2'b00}));
            chk("flash write direction", 32'h1, 32'(flash_we_o));
            wait_idle(r);
            if (f == 0) exp_mem[addr] = byt;
            fail_mode = 1'b0;
            rd_ind(4'h9, r);
            chk("flash data", 32'({exp_mem.exists(addr) ? exp_mem[addr] : 8'hFF, 3'b000}), r);
            rd_ind(4'hA, r);
            chk("address readback", 32'({addr, 1'b0}), r);
        end
        lat = 10'h12C;
        fail_mode = 1'b1;
        v = 32'(req_count);
        set_ir(4'h9);
        scan(1'b0, 2, 32'h2, r);
        chk("flash read direction", 32'h0, 32'(flash_we_o));
        scan(1'b0, 1, 32'h0, r);
        chk("busy set", 32'h1, r);
        scan(1'b0, 12, 32'hC00 | 32'({byt, 2'b00}), r);
        wait_idle(r);
        chk("fail flag", 32'h4, r & 32'h7);
        chk("requests", v + 32'h1, 32'(req_count));
        for (int k = 0; k < 3; k++) begin
            byt = {1'(k), 7'($random(seed))};
            wr_ind(k == 2 ? 4'hB : 4'h8, 8, 32'(byt));
            chk("register", 32'(byt), 32'(k == 2 ? flash_scale_o : flash_ctrl_o));
            if (k < 2) chk("scratchpad", 32'(byt[7]), 32'(flash_scratch_o));
            rd_ind(k == 2 ? 4'hB : 4'h8, r);
            chk("readback", 32'({byt, 1'b0}), r);
        end
        tally_and_finish();
    end

    initial begin
        #3000000;
        n_fail++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
